// *** common/sram_timing_pkg.sv ***
// constants, widths and timing figures shared by the board timing logic
package sram_timing_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W       = 14;
	localparam int DATA_W       = 16;
	localparam int STAGES       = 8;
	localparam int SYNC_DEPTH   = 2;

	// ----------------------------------------------------------------
	// timing figures in nanoseconds
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 25;
	localparam int CYCLE_NS        = 80;
	localparam int LATCH_OPEN_NS   = 50;
	localparam int WRITE_END_NS    = 42;
	localparam int OE_OFF_NS       = 70;

	// ----------------------------------------------------------------
	// conversions: least times round up, longest times round down
	// ----------------------------------------------------------------
	function automatic int least_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : least_cycles

	function automatic int most_cycles(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : most_cycles

	// stage index at which the address latch reopens
	localparam int LATCH_OPEN_STAGE = least_cycles(LATCH_OPEN_NS);
	// number of stages the cycle occupies
	localparam int CYCLE_STAGES     = least_cycles(CYCLE_NS);
	// write strobe covers stages 0 .. WRITE_STAGES-1
	localparam int WRITE_STAGES     = most_cycles(WRITE_END_NS);
	// output enable covers stages 0 .. OE_STAGES-1
	localparam int OE_STAGES        = most_cycles(OE_OFF_NS);

	// ----------------------------------------------------------------
	// stage masks and reset values
	// ----------------------------------------------------------------
	localparam logic [STAGES-1:0] CYCLE_MASK = STAGES'((1 << CYCLE_STAGES) - 1);
	localparam logic [STAGES-1:0] WRITE_MASK = STAGES'((1 << WRITE_STAGES) - 1);
	localparam logic [STAGES-1:0] OE_MASK    = STAGES'((1 << OE_STAGES) - 1);
	localparam logic [STAGES-1:0] STAGES_RST = '0;
	localparam logic [ADDR_W-1:0] ADDR_RST   = '0;
	localparam logic [DATA_W-1:0] DATA_RST   = '0;

endpackage : sram_timing_pkg

// *** rtl/request_sync.sv ***
// two-flop synchroniser for the asynchronous memory request
module request_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// raw and synchronised request
	input  wire logic async_in,
	output logic      sync_out
);

	logic [sram_timing_pkg::SYNC_DEPTH-1:0] chain;

	// the first flop is read only by the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chain <= '0;
		end else begin
			chain <= {chain[sram_timing_pkg::SYNC_DEPTH-2:0], async_in};
		end
	end

	assign sync_out = chain[sram_timing_pkg::SYNC_DEPTH-1];

endmodule : request_sync

// *** rtl/sram_board_cycle_timing.sv ***
// cycle timing and control for a static ram board on a shared bidirectional bus
//
// How it works
// - reopen address latch 50 ns into cycle
// - latch stays open until next request closes
// - buffered memory request closes the address latch
// - write strobe inside address and data stability
// - write width from generator, never spills over
// - latch write data; read through three-state
// - drive bus only on selected reads
// - release bus before next cycle begins
// - request flop feeding 8-stage shift register
// - request rising edge sets request flop
// - first stage clears request flop: one-period pulse
// - cycle start lags request by clock latency
module sram_board_cycle_timing (
	// clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	// system bus control
	input  wire logic                               memory_request,
	input  wire logic                               write_command,
	input  wire logic                               board_select,
	input  wire logic                               clear_overlap,
	// system bus address
	input  wire logic [sram_timing_pkg::ADDR_W-1:0] bus_address,
	// system bus data, three signals for the bidirectional lines
	input  wire logic [sram_timing_pkg::DATA_W-1:0] bus_data_in,
	output logic      [sram_timing_pkg::DATA_W-1:0] bus_data_out,
	output logic                                    bus_data_oe,
	// memory array side
	output logic      [sram_timing_pkg::ADDR_W-1:0] mem_address,
	output logic      [sram_timing_pkg::DATA_W-1:0] mem_write_data,
	input  wire logic [sram_timing_pkg::DATA_W-1:0] mem_read_data,
	output logic                                    mem_chip_select,
	output logic                                    mem_write_strobe,
	// status
	output logic                                    latch_open,
	output logic                                    first_stage_output,
	output logic                                    cycle_active,
	output logic                                    overlap_error
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// true when any stage inside the mask holds the travelling one
	function automatic logic in_window(
		input logic [sram_timing_pkg::STAGES-1:0] chain,
		input logic [sram_timing_pkg::STAGES-1:0] mask
	);
		return |(chain & mask);
	endfunction : in_window

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                               request_sync_q;
	logic                               request_prev;
	logic                               request_ff;
	logic [sram_timing_pkg::STAGES-1:0] stages;
	logic                               write_cycle;
	logic                               selected;

	wire logic                               request_rise;
	wire logic                               serial_a;
	wire logic                               serial_b;
	wire logic                               cycle_busy;
	wire logic [sram_timing_pkg::STAGES-1:0] next_stages;
	wire logic                               next_request_ff;
	wire logic                               next_latch_open;
	wire logic                               next_write_strobe;
	wire logic                               next_oe;
	wire logic                               next_chip_select;
	wire logic                               next_overlap;
	wire logic [sram_timing_pkg::ADDR_W-1:0] next_address;
	wire logic [sram_timing_pkg::DATA_W-1:0] next_write_data;
	wire logic                               reopen_point;

	// ----------------------------------------------------------------
	// request synchronisation
	// ----------------------------------------------------------------

	// a set-up violation on the raw request would otherwise leave the
	// first stage metastable and yield a doubled or runt pulse
	request_sync u_request_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (memory_request),
		.sync_out (request_sync_q)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			request_prev <= 1'b0;
		end else begin
			request_prev <= request_sync_q;
		end
	end

	// the buffered request edge; adds synchroniser latency to start
	assign request_rise = request_sync_q & ~request_prev;

	// ----------------------------------------------------------------
	// pulse generator: request flop and shift register
	// ----------------------------------------------------------------

	// busy for the full cycle length counted from the first stage
	assign cycle_busy = in_window(stages, sram_timing_pkg::CYCLE_MASK);

	// serial inputs: armed request and an idle generator
	assign serial_a = request_ff;
	assign serial_b = ~cycle_busy;

	// the one enters stage 0 on the first edge with both inputs high
	assign next_stages = {stages[sram_timing_pkg::STAGES-2:0], serial_a & serial_b};

	// set by the request edge, cleared by the first stage; a new edge
	// in the clearing cycle wins so it is not lost
	assign next_request_ff = request_rise ? 1'b1
	                       : (stages[0] ? 1'b0 : request_ff);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			request_ff <= 1'b0;
			stages     <= sram_timing_pkg::STAGES_RST;
		end else begin
			request_ff <= next_request_ff;
			stages     <= next_stages;
		end
	end

	// ----------------------------------------------------------------
	// cycle attributes captured with the request
	// ----------------------------------------------------------------

	// type and board selection are frozen at the request edge so a
	// later change on the bus cannot alter a cycle already running
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			write_cycle <= 1'b0;
			selected    <= 1'b0;
		end else if (request_rise) begin
			write_cycle <= write_command;
			selected    <= board_select;
		end
	end

	// ----------------------------------------------------------------
	// address latch
	// ----------------------------------------------------------------

	assign reopen_point = stages[sram_timing_pkg::LATCH_OPEN_STAGE];

	// closes on the request edge, reopens partway through the cycle
	// and then waits, however long the master skips cycles
	assign next_latch_open = request_rise ? 1'b0
	                       : (reopen_point ? 1'b1
	                       : latch_open);

	// flow-through while open; the closing edge takes the last value
	assign next_address = latch_open ? bus_address : mem_address;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			latch_open  <= 1'b1;
			mem_address <= sram_timing_pkg::ADDR_RST;
		end else begin
			latch_open  <= next_latch_open;
			mem_address <= next_address;
		end
	end

	// ----------------------------------------------------------------
	// write data latch
	// ----------------------------------------------------------------

	// data is taken with the address so it is stable over the whole
	// strobe; reads leave the previous value in place
	assign next_write_data = (request_rise & write_command) ? bus_data_in
	                       : mem_write_data;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_write_data <= sram_timing_pkg::DATA_RST;
		end else begin
			mem_write_data <= next_write_data;
		end
	end

	// ----------------------------------------------------------------
	// write strobe and chip select
	// ----------------------------------------------------------------

	// width comes only from the travelling pulse; it ends well before
	// the latch reopens, so neither the address nor the next cycle's
	// select can overlap it
	assign next_write_strobe = selected & write_cycle
	                         & in_window(stages, sram_timing_pkg::WRITE_MASK);

	assign next_chip_select  = selected & cycle_busy;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_write_strobe <= 1'b0;
			mem_chip_select  <= 1'b0;
		end else begin
			mem_write_strobe <= next_write_strobe;
			mem_chip_select  <= next_chip_select;
		end
	end

	// ----------------------------------------------------------------
	// read data buffers
	// ----------------------------------------------------------------

	// enable only for a selected read, and drop it before the cycle
	// ends so write data has time to settle on the shared lines
	assign next_oe = selected & ~write_cycle
	               & in_window(stages, sram_timing_pkg::OE_MASK);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_data_oe  <= 1'b0;
			bus_data_out <= sram_timing_pkg::DATA_RST;
		end else begin
			bus_data_oe  <= next_oe;
			bus_data_out <= mem_read_data;
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------

	// a request edge while a cycle still runs or one is pending breaks
	// the master's spacing; flag it, set beats clear
	assign next_overlap = (request_rise & (cycle_busy | request_ff)) ? 1'b1
	                    : (clear_overlap ? 1'b0 : overlap_error);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_stage_output <= 1'b0;
			cycle_active       <= 1'b0;
			overlap_error      <= 1'b0;
		end else begin
			first_stage_output <= next_stages[0];
			cycle_active       <= in_window(next_stages, sram_timing_pkg::CYCLE_MASK);
			overlap_error      <= next_overlap;
		end
	end

endmodule : sram_board_cycle_timing

// *** verification/sram_board_cycle_timing_properties.sv ***
// concurrent checks on the ports of the board cycle timing logic
module sram_board_cycle_timing_properties (
	// clock and reset
	input wire logic                               sys_clk,
	input wire logic                               rst,
	// request and address
	input wire logic                               memory_request,
	input wire logic [sram_timing_pkg::ADDR_W-1:0] mem_address,
	// control outputs
	input wire logic                               bus_data_oe,
	input wire logic                               mem_chip_select,
	input wire logic                               mem_write_strobe,
	input wire logic                               latch_open,
	input wire logic                               first_stage_output,
	input wire logic                               cycle_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_one_pulse;
		first_stage_output ##1 !first_stage_output;
	endsequence
	sequence s_oe_window;
		bus_data_oe [*2] ##1 !bus_data_oe;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// two sync flops, request flop, then stage 0 with its output copy
	start_latency_a: assert property ($rose(memory_request) |-> ##4 $rose(first_stage_output))
		else $error("timing pulse not four clocks after request");
	pulse_width_a: assert property ($rose(first_stage_output) |-> s_one_pulse)
		else $error("timing pulse not one clock wide");
	strobe_cause_a: assert property ($rose(mem_write_strobe) |-> $fell(first_stage_output) && mem_chip_select && !bus_data_oe)
		else $error("write strobe outside a selected cycle start");
	strobe_width_a: assert property (mem_write_strobe |=> !mem_write_strobe)
		else $error("write strobe longer than one clock");
	oe_select_a: assert property ($rose(bus_data_oe) |-> mem_chip_select && !mem_write_strobe)
		else $error("bus driven outside a selected read");
	oe_release_a: assert property ($rose(bus_data_oe) |-> s_oe_window)
		else $error("bus enable window wrong");
	latch_close_a: assert property ($fell(latch_open) |-> $past(memory_request, 2))
		else $error("address latch closed without a request");
	latch_reopen_a: assert property ($rose(first_stage_output) |-> !latch_open ##3 latch_open)
		else $error("address latch not reopened three clocks after cycle start");
	addr_hold_a: assert property (!latch_open && !$past(latch_open) |-> $stable(mem_address))
		else $error("address moved while latch closed");
	cycle_span_a: assert property ($rose(cycle_active) |-> cycle_active [*4] ##1 !cycle_active)
		else $error("cycle not four stages long");
	read_seen_c: cover property ($rose(bus_data_oe));
endmodule : sram_board_cycle_timing_properties

bind sram_board_cycle_timing sram_board_cycle_timing_properties i_props (.sys_clk(sys_clk), .rst(rst),
	.memory_request(memory_request), .mem_address(mem_address), .bus_data_oe(bus_data_oe),
	.mem_chip_select(mem_chip_select), .mem_write_strobe(mem_write_strobe), .latch_open(latch_open),
	.first_stage_output(first_stage_output), .cycle_active(cycle_active));

// *** verification/bus_master_model.sv ***
// system bus master issuing one memory request at a time
module bus_master_model (
	// clock
	input  wire logic                               sys_clk,
	// request side of the bus
	output logic                                    memory_request,
	output logic                                    write_command,
	output logic                                    board_select,
	output logic      [sram_timing_pkg::ADDR_W-1:0] bus_address,
	output logic      [sram_timing_pkg::DATA_W-1:0] bus_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{memory_request, write_command, board_select, bus_address, bus_data_in} = '0;
	end
	task automatic issue(input logic wr, input logic sel, input logic [sram_timing_pkg::ADDR_W-1:0] addr,
		input logic [sram_timing_pkg::DATA_W-1:0] data, input int hold);
		@(negedge sys_clk);
		{write_command, board_select, bus_address, bus_data_in} = {wr, sel, addr, data};
		memory_request = 1'b1;
		repeat (hold) @(negedge sys_clk);
		memory_request = 1'b0;
		repeat (4) @(negedge sys_clk);
		// no pull on these lines: show a changed value, not the last one
		{write_command, board_select, bus_address, bus_data_in} = ~{wr, sel, addr, data};
		repeat (6) @(negedge sys_clk);
	endtask : issue
	// bare request with the bus fields left as they stand; breaks the spacing on purpose
	task automatic request_pulse(input int hold);
		memory_request = 1'b1;
		repeat (hold) @(negedge sys_clk);
		memory_request = 1'b0;
	endtask : request_pulse
endmodule : bus_master_model

// *** verification/sram_board_cycle_timing_tb_top.sv ***
// self-checking bench for the board cycle timing logic
module sram_board_cycle_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = sram_timing_pkg::ADDR_W;
	localparam int DW = sram_timing_pkg::DATA_W;
	localparam int CS = sram_timing_pkg::CYCLE_STAGES;
	`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
		$display("Error %s expected %0h seen %0h", what, exp, got); end end
	typedef struct {logic wr; logic sel; logic [AW-1:0] addr; logic [DW-1:0] wdata; logic [DW-1:0] rdata;
		int n_stb; int n_oe; int n_cs;} row_t;
	logic          sys_clk, rst, memory_request, write_command, board_select, clear_overlap;
	logic          bus_data_oe, mem_chip_select, mem_write_strobe, latch_open, first_stage_output;
	logic          cycle_active, overlap_error;
	logic [AW-1:0] bus_address, mem_address;
	logic [DW-1:0] bus_data_in, bus_data_out, mem_write_data, mem_read_data, wexp;
	int            n_fail, n_tests;
	row_t          rows [5] = '{
		'{1'b1, 1'b1, 14'h3fff, 16'ha5c3, 16'h0f0f, sram_timing_pkg::WRITE_STAGES, 0, CS},
		'{1'b0, 1'b1, 14'h0000, 16'hffff, 16'h5a3c, 0, sram_timing_pkg::OE_STAGES, CS},
		'{1'b1, 1'b0, 14'h1234, 16'h8001, 16'hbeef, 0, 0, 0},
		'{1'b0, 1'b0, 14'h2aaa, 16'h7ffe, 16'h1111, 0, 0, 0},
		'{1'b1, 1'b1, 14'h1555, 16'h0001, 16'hc3c3, sram_timing_pkg::WRITE_STAGES, 0, CS}};

	sram_board_cycle_timing i_sram_board_cycle_timing (.sys_clk(sys_clk), .rst(rst),
		.memory_request(memory_request), .write_command(write_command), .board_select(board_select),
		.clear_overlap(clear_overlap), .bus_address(bus_address), .bus_data_in(bus_data_in),
		.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .mem_address(mem_address),
		.mem_write_data(mem_write_data), .mem_read_data(mem_read_data), .mem_chip_select(mem_chip_select),
		.mem_write_strobe(mem_write_strobe), .latch_open(latch_open), .first_stage_output(first_stage_output),
		.cycle_active(cycle_active), .overlap_error(overlap_error));
	bus_master_model i_bus_master_model (.sys_clk(sys_clk), .memory_request(memory_request),
		.write_command(write_command), .board_select(board_select), .bus_address(bus_address),
		.bus_data_in(bus_data_in));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	// one request, watched clock by clock; hold is how long the master keeps it up
	task automatic run_row(input row_t r, input int hold, input int len);
		int            lat, nstb, noe, ncs, nfso;
		logic [AW-1:0] a_seen;
		logic [DW-1:0] w_seen;
		{lat, nstb, noe, ncs, nfso} = '0;
		mem_read_data = r.rdata;
		if (r.wr) wexp = r.wdata;
		fork
			i_bus_master_model.issue(r.wr, r.sel, r.addr, r.wdata, hold);
			begin
				@(negedge sys_clk);
				repeat (len) begin
					@(negedge sys_clk);
					if (nfso == 0) lat++;
					if (first_stage_output === 1'b1) begin
						if (nfso == 0) {a_seen, w_seen} = {mem_address, mem_write_data};
						nfso++;
					end
					if (mem_write_strobe === 1'b1) nstb++;
					if (mem_chip_select === 1'b1) ncs++;
					if (bus_data_oe === 1'b1) begin
						noe++;
						`CHK("bus_data_out", r.rdata, bus_data_out)
					end
				end
			end
		join
		`CHK("latency", sram_timing_pkg::SYNC_DEPTH + 2, lat)
		`CHK("pulse count", 1, nfso)
		`CHK("strobe cycles", r.n_stb, nstb)
		`CHK("enable cycles", r.n_oe, noe)
		`CHK("select cycles", r.n_cs, ncs)
		`CHK("held address", r.addr, a_seen)
		`CHK("write data", wexp, w_seen)
		`CHK("latch open", 1'b1, latch_open)
		`CHK("flow address", ~r.addr, mem_address)
		$display("test request hold %0d done", hold);
	endtask : run_row

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{n_fail, n_tests} = '0;
		{rst, clear_overlap, mem_read_data, wexp} = {1'b1, 1'b0, 16'h0000, 16'h0000};
		repeat (8) @(negedge sys_clk);
		`CHK("latch in reset", 1'b1, latch_open)
		`CHK("strobe in reset", 1'b0, mem_write_strobe)
		rst = 1'b0;
		$display("test reset done");
		foreach (rows[i]) run_row(rows[i], 3, 13);
		// request held far past the pulse must still give a single pulse
		run_row(rows[4], 12, 20);
		`CHK("no overlap", 1'b0, overlap_error)
		// second request lands while the first cycle still runs: flagged, then cleared
		fork
			i_bus_master_model.issue(1'b0, 1'b1, 14'h0aaa, 16'h0000, 2);
			begin
				repeat (6) @(negedge sys_clk);
				i_bus_master_model.request_pulse(2);
			end
		join
		`CHK("overlap set", 1'b1, overlap_error)
		clear_overlap = 1'b1;
		@(negedge sys_clk);
		clear_overlap = 1'b0;
		`CHK("overlap cleared", 1'b0, overlap_error)
		$display("test overlap done");
		// reset lands on the edge that would raise the strobe
		fork
			i_bus_master_model.issue(1'b1, 1'b1, 14'h0155, 16'h3c3c, 3);
			begin
				repeat (5) @(negedge sys_clk);
				{rst, clear_overlap} = 2'b11;
				@(negedge sys_clk);
				`CHK("strobe cut", 1'b0, mem_write_strobe)
				`CHK("select cut", 1'b0, mem_chip_select)
				`CHK("latch reset", 1'b1, latch_open)
				repeat (2) @(negedge sys_clk);
				{rst, clear_overlap} = 2'b00;
			end
		join
		repeat (4) @(negedge sys_clk);
		`CHK("quiet after reset", 1'b0, bus_data_oe)
		$display("test reset mid cycle done");
		summarize();
	end

	// about 130 clocks of tests; allow fifteen times that
	initial begin
		#50us;
		n_fail++;
		summarize();
	end
endmodule : sram_board_cycle_timing_tb_top
